// ---- cps_pkg.sv ----
package cps_pkg;
  localparam int AW = 12;
  localparam int DW = 16;
  localparam logic [11:0] OFF_PERR = 12'h60A;
  localparam logic [11:0] OFF_PERR_IE = 12'h60C;
  localparam logic [11:0] OFF_CFG = 12'h60E;
  localparam logic [11:0] OFF_LOST = 12'h610;
  localparam logic [11:0] OFF_PIN = 12'h614;
  localparam logic [11:0] OFF_BASE = 12'h620;
  localparam logic [11:0] OFF_VCI = 12'h622;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam int PERR_LSB = 3;
  localparam int NPORT = 3;
  localparam int ALM_LSB = 6;
  localparam int PIN_ALM_LSB = 8;
  localparam int PIN_LED_LSB = 10;
  localparam int NLED = 4;
  localparam logic [15:0] MASK_PERR = 16'h0038;
  localparam logic [15:0] MASK_CFG = 16'hFFFF;
  localparam logic [15:0] MASK_PIN_W = 16'h00FF;
  localparam logic [1:0] NULL_KEEP = 2'h0;
  localparam logic [1:0] NULL_UNI = 2'h2;
  localparam logic [1:0] NULL_NNI = 2'h3;
  localparam logic [1:0] ALM_OFF = 2'h0;
  localparam logic [1:0] ALM_HIGH = 2'h1;
  localparam logic [1:0] ALM_LOW = 2'h2;
  localparam logic [1:0] PIN_TRI = 2'h0;
  localparam logic [1:0] PIN_LED = 2'h1;
  localparam logic [1:0] PIN_LOW = 2'h2;
  localparam logic [1:0] PIN_HIGH = 2'h3;
  localparam logic [31:0] IDLE_HDR_UNI = 32'h00000000;
  localparam logic [31:0] IDLE_MASK_UNI = 32'h0FFFFFFF;
  localparam logic [31:0] IDLE_HDR_NNI = 32'h00000000;
  localparam logic [31:0] IDLE_MASK_NNI = 32'hFFFFFFFF;
  localparam logic [2:0] SIZE_SHIFT_BASE = 3'h0;
endpackage : cps_pkg

// ---- cps_null_det.sv ----
`timescale 1ns/1ps
module cps_null_det (
  input wire logic [1:0] mode,
  input wire logic [31:0] hdr,
  output logic drop
);
  wire logic uni_hit;
  wire logic nni_hit;
  assign uni_hit = (hdr & cps_pkg::IDLE_MASK_UNI) == cps_pkg::IDLE_HDR_UNI;
  assign nni_hit = (hdr & cps_pkg::IDLE_MASK_NNI) == cps_pkg::IDLE_HDR_NNI;
  // Reserved mode keeps cells, so a bad setting never silently loses traffic.
  assign drop = (mode == cps_pkg::NULL_UNI) ? uni_hit :
                (mode == cps_pkg::NULL_NNI) ? nni_hit : 1'b0;
endmodule : cps_null_det

// ---- cps_pin_ctl.sv ----
`timescale 1ns/1ps
module cps_pin_ctl (
  input wire logic [1:0] conf,
  input wire logic led_on,
  output logic pin_o,
  output logic pin_oe_n
);
  assign pin_oe_n = (conf == cps_pkg::PIN_TRI);
  assign pin_o = (conf == cps_pkg::PIN_HIGH) ? 1'b1 :
                 (conf == cps_pkg::PIN_LOW) ? 1'b0 : led_on;
endmodule : cps_pin_ctl

// ---- cps_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - Ports A, B, C parity error flags sit in status bits 3, 4, 5.
// - Interrupt asserts only when a flag and its same-position enable are both one.
// - Null deletion field: 00 keep, 10 delete UNI, 11 delete NNI, 01 reserved.
// - Null deletion fields for A, B, C are bits 1:0, 3:2, 5:4.
// - Alarm field 7:6: 00 never, 01 active high, 10 active low, 11 reserved.
// - Sixteen-bit readable counter counts cells lost in any output FIFO.
// - LED pin fields: 00 tri-state, 01 LED, 10 drive low, 11 drive high.
// - Pin register bits 8 and 9 show live alarm inputs of A and B.
// - Bits 10 to 13 show A tx, A rx, B tx, B rx LED state.
// - Port A table base is a 4-bit field in megabyte units.
// - Table size field selects 128K, 256K, 512K or 1024K entries.
// - Five-bit field gives VCI bits used for the port A table index.
// - Reserved bits of status, enable and pin registers read as zero.
module cps_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic [2:0] parity_err,
  input wire logic [2:0] cell_lost,
  input wire logic [1:0] alarm_in,
  output logic [1:0] alarm_active,
  input wire logic [3:0] led_state,
  output logic [3:0] led_o,
  output logic [3:0] led_oe_n,
  input wire logic [31:0] hdr_a,
  input wire logic [31:0] hdr_b,
  input wire logic [31:0] hdr_c,
  output logic [2:0] null_drop,
  output logic [3:0] lut_base_mb,
  output logic [10:0] lut_entries_k,
  output logic [4:0] vci_index_bits
);
  logic [15:0] perr_q;
  logic [15:0] perr_d;
  logic [15:0] ie_q;
  logic [15:0] cfg_q;
  logic [15:0] lost_q;
  logic [15:0] pin_q;
  logic [15:0] base_q;
  logic [15:0] vci_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  function automatic logic [15:0] masked_write(input logic [15:0] old, input logic [15:0] nw,
                                               input logic [15:0] m);
    masked_write = (old & ~m) | (nw & m);
  endfunction : masked_write

  wire logic sel_perr;
  wire logic sel_ie;
  wire logic sel_cfg;
  wire logic sel_pin;
  wire logic sel_base;
  wire logic sel_vci;
  assign sel_perr = addr == cps_pkg::OFF_PERR;
  assign sel_ie = addr == cps_pkg::OFF_PERR_IE;
  assign sel_cfg = addr == cps_pkg::OFF_CFG;
  assign sel_pin = addr == cps_pkg::OFF_PIN;
  assign sel_base = addr == cps_pkg::OFF_BASE;
  assign sel_vci = addr == cps_pkg::OFF_VCI;

  // New errors win over a read-clear in the same cycle so none is lost.
  wire logic [15:0] perr_set;
  assign perr_set = {10'h000, parity_err, 3'h0} & cps_pkg::MASK_PERR;
  assign perr_d = ((rd && sel_perr) ? 16'h0000 : perr_q) | perr_set;

  assign irq = |(perr_q & ie_q & cps_pkg::MASK_PERR);

  wire logic [1:0] alm_mode;
  assign alm_mode = cfg_q[cps_pkg::ALM_LSB +: 2];
  assign alarm_active = (alm_mode == cps_pkg::ALM_HIGH) ? alarm_in :
                        (alm_mode == cps_pkg::ALM_LOW) ? ~alarm_in : 2'h0;

  // Live readback takes the inputs directly so software sees the pins now.
  wire logic [15:0] pin_rd;
  assign pin_rd = {2'h0, led_state, alarm_in, pin_q[7:0]};

  genvar gi;
  for (gi = 0; gi < cps_pkg::NPORT; gi++) begin : g_null
    cps_null_det u_null (
      .mode(cfg_q[2*gi +: 2]),
      .hdr(gi == 0 ? hdr_a : (gi == 1 ? hdr_b : hdr_c)),
      .drop(null_drop[gi])
    );
  end
  for (gi = 0; gi < cps_pkg::NLED; gi++) begin : g_led
    cps_pin_ctl u_pin (
      .conf(pin_q[2*gi +: 2]),
      .led_on(led_state[gi]),
      .pin_o(led_o[gi]),
      .pin_oe_n(led_oe_n[gi])
    );
  end

  assign lut_base_mb = base_q[3:0];
  // Entry count is shown in units of 1K, so 128K needs only eleven bits at 1024K.
  assign lut_entries_k = 11'h080 << base_q[5:4];
  assign vci_index_bits = vci_q[4:0];

  wire logic [1:0] lost_inc;
  assign lost_inc = 2'(cell_lost[0]) + 2'(cell_lost[1]) + 2'(cell_lost[2]);

  always_comb begin
    rdata_d = 16'h0000;
    case (addr)
      cps_pkg::OFF_PERR: rdata_d = perr_q & cps_pkg::MASK_PERR;
      cps_pkg::OFF_PERR_IE: rdata_d = ie_q & cps_pkg::MASK_PERR;
      cps_pkg::OFF_CFG: rdata_d = cfg_q;
      cps_pkg::OFF_LOST: rdata_d = lost_q;
      cps_pkg::OFF_PIN: rdata_d = pin_rd;
      cps_pkg::OFF_BASE: rdata_d = base_q;
      cps_pkg::OFF_VCI: rdata_d = vci_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Reserved writable bits are stored as written; software must keep them zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perr_q <= cps_pkg::RST_VAL;
      ie_q <= cps_pkg::RST_VAL;
      cfg_q <= cps_pkg::RST_VAL;
      lost_q <= cps_pkg::RST_VAL;
      pin_q <= cps_pkg::RST_VAL;
      base_q <= cps_pkg::RST_VAL;
      vci_q <= cps_pkg::RST_VAL;
      rdata_q <= cps_pkg::RST_VAL;
    end else begin
      perr_q <= perr_d;
      lost_q <= lost_q + 16'(lost_inc);
      if (rd) rdata_q <= rdata_d;
      if (wr && sel_ie) ie_q <= masked_write(ie_q, wdata, cps_pkg::MASK_PERR);
      if (wr && sel_cfg) cfg_q <= masked_write(cfg_q, wdata, cps_pkg::MASK_CFG);
      if (wr && sel_pin) pin_q <= masked_write(pin_q, wdata, cps_pkg::MASK_PIN_W);
      if (wr && sel_base) base_q <= wdata;
      if (wr && sel_vci) vci_q <= wdata;
    end
  end
  assign rdata = rdata_q;
endmodule : cps_regs

// ---- cps_phy_model.sv ----
`timescale 1ns/1ps
module cps_phy_model (
  input wire logic clk,
  output logic [2:0] parity_err,
  output logic [2:0] cell_lost,
  output logic [1:0] alarm_in,
  output logic [3:0] led_state
);
  initial begin
    parity_err = 3'h0;
    cell_lost = 3'h0;
    alarm_in = 2'h0;
    led_state = 4'h0;
  end
  // Error and loss strobes last one clock, because a real port reports each event once.
  task pulse(input logic [2:0] pe, input logic [2:0] cl);
    @(posedge clk);
    parity_err <= pe;
    cell_lost <= cl;
    @(posedge clk);
    parity_err <= 3'h0;
    cell_lost <= 3'h0;
    @(negedge clk);
  endtask : pulse
endmodule : cps_phy_model

// ---- cps_regs_monitor.sv ----
`timescale 1ns/1ps
module cps_regs_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic irq,
  input wire logic [2:0] parity_err,
  input wire logic [1:0] alarm_in,
  input wire logic [1:0] alarm_active,
  input wire logic [3:0] led_state,
  input wire logic [31:0] hdr_a,
  input wire logic [2:0] null_drop,
  input wire logic [10:0] lut_entries_k
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_flag_rd; rd && addr == cps_pkg::OFF_PERR; endsequence
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(parity_err != 3'h0 || wr))
    else $error("irq rose without cause");
  AST_IRQ_CLR: assert property (s_flag_rd ##0 parity_err == 3'h0 |=> !irq)
    else $error("irq kept after flag read");
  AST_PERR_RSVD: assert property (s_flag_rd |=> rdata[2:0] == 3'h0 && rdata[15:6] == 10'h000)
    else $error("flag reserved bits set");
  AST_PIN_LIVE: assert property (rd && addr == cps_pkg::OFF_PIN |=>
    rdata[13:10] == $past(led_state) && rdata[15:14] == 2'h0) else $error("pin readback wrong");
  AST_LUT_ENC: assert property (lut_entries_k inside {11'h080, 11'h100, 11'h200, 11'h400})
    else $error("table size out of set");
  AST_LUT_HOLD: assert property (!wr |=> $stable(lut_entries_k))
    else $error("table size moved without write");
  AST_NULL_HDR: assert property (null_drop[0] |-> hdr_a[27:0] == 28'h0)
    else $error("non-idle cell dropped");
  AST_ALM_HOLD: assert property (!$past(wr) && $stable(alarm_in) |-> $stable(alarm_active))
    else $error("alarm moved without cause");
endmodule : cps_regs_monitor
bind cps_regs cps_regs_monitor mon_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .parity_err(parity_err), .alarm_in(alarm_in), .hdr_a(hdr_a),
  .alarm_active(alarm_active), .led_state(led_state), .null_drop(null_drop),
  .lut_entries_k(lut_entries_k));

// ---- tb_cell_port_status_control_regs.sv ----
`timescale 1ns/1ps
module tb_cell_port_status_control_regs;
  typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] e;} cps_row_t;
  logic clk, rst_n, wr, rd, irq;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [31:0] hdr_a;
  logic [2:0] parity_err, cell_lost, null_drop;
  logic [1:0] alarm_in, alarm_active;
  logic [3:0] led_state, led_o, led_oe_n, lut_base_mb;
  logic [10:0] lut_entries_k;
  logic [4:0] vci_index_bits;
  int n_mismatch = 0;
  int compares = 0;
  // Rows for the control, base and width registers keep their reserved bits zero.
  cps_row_t rows[7] = '{'{cps_pkg::OFF_CFG, 16'h00E6, 16'h00E6},
    '{cps_pkg::OFF_PERR_IE, 16'hFFFF, 16'h0038}, '{cps_pkg::OFF_PIN, 16'hFFFF, 16'h00FF},
    '{cps_pkg::OFF_BASE, 16'h0035, 16'h0035}, '{cps_pkg::OFF_VCI, 16'h001F, 16'h001F},
    '{cps_pkg::OFF_PERR, 16'hFFFF, 16'h0000}, '{12'h600, 16'hFFFF, 16'h0000}};
  cps_phy_model phy_u (.clk(clk), .parity_err(parity_err), .cell_lost(cell_lost),
    .alarm_in(alarm_in), .led_state(led_state));
  cps_regs dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .parity_err(parity_err), .cell_lost(cell_lost),
    .alarm_in(alarm_in), .alarm_active(alarm_active), .led_state(led_state), .led_o(led_o),
    .led_oe_n(led_oe_n), .hdr_a(hdr_a), .hdr_b(32'h0), .hdr_c(32'h0), .null_drop(null_drop),
    .lut_base_mb(lut_base_mb), .lut_entries_k(lut_entries_k), .vci_index_bits(vci_index_bits));
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin n_mismatch++; $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask : chk
  task wreg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    @(negedge clk);
  endtask : wreg
  task rreg(input logic [11:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask : rreg
  task wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // The run needs about a hundred cycles, so this limit leaves ample margin.
  initial begin #200us; n_mismatch++; wrap_up(); end
  initial begin
    addr = 12'h000; wdata = 16'h0000; wr = 1'b0; rd = 1'b0; hdr_a = 32'h0; rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rreg(rows[i].a); chk("reset value", cps_pkg::RST_VAL, v);
      wreg(rows[i].a, rows[i].d); rreg(rows[i].a); chk("readback", rows[i].e, v);
    end
    chk("base", 16'h0005, 16'(lut_base_mb));
    chk("vci bits", 16'h001F, 16'(vci_index_bits));
    $display("register rows done");
    @(posedge clk) phy_u.led_state <= 4'h5;
    for (int m = 0; m < 4; m++) begin
      wreg(cps_pkg::OFF_CFG, 16'(m * 65)); wreg(cps_pkg::OFF_PIN, 16'(m * 85));
      wreg(cps_pkg::OFF_BASE, 16'(m * 16));
      @(posedge clk); hdr_a <= 32'h0; phy_u.alarm_in <= 2'h1;
      @(negedge clk);
      chk("drop idle", 16'(m > 1), 16'(null_drop[0]));
      chk("alarm high", 16'(m == 1), 16'(alarm_active[0]));
      chk("entries", 16'(128 << m), 16'(lut_entries_k));
      chk("led enable", m == 0 ? 16'h000F : 16'h0000, 16'(led_oe_n));
      if (m != 0) chk("led drive", m == 1 ? 16'h5 : m == 2 ? 16'h0 : 16'hF, 16'(led_o));
      @(posedge clk); hdr_a <= 32'hF0000000; phy_u.alarm_in <= 2'h0;
      @(negedge clk);
      chk("drop gfc", 16'(m == 2), 16'(null_drop[0]));
      chk("alarm low", 16'(m == 2), 16'(alarm_active[0]));
    end
    wreg(cps_pkg::OFF_CFG, 16'h0038); chk("drop ports", 16'h0006, 16'(null_drop));
    @(posedge clk) phy_u.alarm_in <= 2'h2;
    rreg(cps_pkg::OFF_PIN); chk("pin", 16'h16FF, v);
    $display("mode tests done");
    wreg(cps_pkg::OFF_PERR_IE, 16'h0008);
    phy_u.pulse(3'h1, 3'h7); chk("irq set", 16'h1, 16'(irq));
    rreg(cps_pkg::OFF_PERR); chk("flags", 16'h0008, v);
    chk("irq clear", 16'h0, 16'(irq));
    phy_u.pulse(3'h6, 3'h7); chk("irq masked", 16'h0, 16'(irq));
    rreg(cps_pkg::OFF_PERR); chk("flags", 16'h0030, v);
    rreg(cps_pkg::OFF_LOST); chk("lost", 16'h0006, v);
    $display("event tests done");
    wrap_up();
  end
endmodule : tb_cell_port_status_control_regs
